// *** verilog/acs_regs.svh ***
// Constants of the conversion sequencer: command codes, bit counts, timing tables, resets.
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH

// Single conversion cycles, indexed by rate codes 0000-0100 then 1000-1100.
`define ACS_SINGLE_F0 '{22'd171448, 22'd335288, 22'd662968, 22'd1318328, 22'd2629048, \
    22'd7592, 22'd17848, 22'd28088, 22'd48568, 22'd89528}
`define ACS_SINGLE_F1 '{22'd205738, 22'd402346, 22'd795562, 22'd1581994, 22'd3154858, \
    22'd9110, 22'd21418, 22'd33706, 22'd58282, 22'd107434}
// First continuous conversion cycles.
`define ACS_FIRST_F0 '{22'd89528, 22'd171448, 22'd335288, 22'd662968, 22'd1318328, \
    22'd2472, 22'd12728, 22'd17848, 22'd28088, 22'd48568}
`define ACS_FIRST_F1 '{22'd107434, 22'd205738, 22'd402346, 22'd795562, 22'd1581994, \
    22'd2966, 22'd15274, 22'd21418, 22'd33706, 22'd58282}
// Later continuous conversion cycles.
`define ACS_NEXT_F0 '{22'd40960, 22'd81920, 22'd163840, 22'd327680, 22'd655360, \
    22'd1280, 22'd2560, 22'd5120, 22'd10240, 22'd20480}
`define ACS_NEXT_F1 '{22'd49152, 22'd98304, 22'd196608, 22'd393216, 22'd786432, \
    22'd1536, 22'd3072, 22'd6144, 22'd12288, 22'd24576}

// Calibration is shorter than a single conversion by these cycles.
`define ACS_OFS_LESS_F0  22'd608
`define ACS_OFS_LESS_F1  22'd729
`define ACS_GAIN_LESS_F0 22'd128
`define ACS_GAIN_LESS_F1 22'd153

`define ACS_CMD_SINGLE   8'h01
`define ACS_CMD_CONT     8'h02
`define ACS_CAL_BIT      7
`define ACS_CAL_GAIN_BIT 0
`define ACS_EXIT_BYTE    8'hFF
`define ACS_BYTE_LAST    6'h07
`define ACS_READ_LAST    6'h27
`define ACS_RISE_CYC     5'h10
`define ACS_GAIN_RESET   32'h01000000
`define ACS_OFS_RESET    32'h00000000
`define ACS_GAIN_MASK    32'h3FFFFFFF
`define ACS_OFS_MASK     32'hFFFFFF00
// Offset-to-output gain 1.83007966 in signed Q16.
`define ACS_OFS_SCALE    18'sh1D480

`endif

// *** verilog/acs_pkg.sv ***
// Types of the conversion sequencer.
package acs_pkg;
    typedef enum logic [5:0] {
        PS_CMD   = 6'h01,
        PS_CAL   = 6'h02,
        PS_WAIT  = 6'h04,
        PS_READY = 6'h08,
        PS_FLAG  = 6'h10,
        PS_SHIFT = 6'h20
    } acs_port_e;
endpackage

// *** verilog/acs_stream_if.sv ***
// Valid/ready word stream between the result path and the result FIFO.
interface acs_stream_if #(parameter int W = 32);
    logic [W-1:0] in_data;
    logic         in_valid;
    logic         in_ready;
    logic [W-1:0] out_data;
    logic         out_valid;
    logic         out_ready;
    modport fifo (input in_data, in_valid, out_ready, output in_ready, out_data, out_valid);
    modport user (output in_data, in_valid, out_ready, input in_ready, out_data, out_valid);
endinterface

// *** verilog/acs_sync.sv ***
// Two-stage synchroniser for inputs from outside the clock domain.
module acs_sync #(
    parameter int           W    = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  logic         clk,
    input  logic         rst,
    input  logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= INIT;
            q    <= INIT;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

// *** verilog/acs_fifo.sv ***
// Result FIFO: circular store with a registered output word.
module acs_fifo #(
    parameter int W     = 32,
    parameter int DEPTH = 16
) (
    input logic        clk,
    input logic        rst,
    acs_stream_if.fifo s
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   fill;
    logic          push;
    logic          load;

    assign s.in_ready = (fill != (AW+1)'(DEPTH));
    assign push       = s.in_valid && s.in_ready;
    assign load       = (fill != '0) && (!s.out_valid || s.out_ready);

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= s.in_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill   <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + AW'(1);
            end
            if (load) begin
                rd_ptr <= rd_ptr + AW'(1);
            end
            if (push && !load) begin
                fill <= fill + (AW+1)'(1);
            end else if (!push && load) begin
                fill <= fill - (AW+1)'(1);
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s.out_valid <= 1'b0;
            s.out_data  <= '0;
        end else if (load) begin
            s.out_valid <= 1'b1;
            s.out_data  <= mem[rd_ptr];
        end else if (s.out_ready) begin
            s.out_valid <= 1'b0;
        end
    end
endmodule

// *** verilog/acs_sequencer.sv ***
// Conversion sequencer: serial port modes, conversion pacing, calibration and result path.
`include "acs_regs.svh"
module acs_sequencer #(
    parameter logic [21:0] SINGLE_F0 [10] = `ACS_SINGLE_F0,
    parameter logic [21:0] SINGLE_F1 [10] = `ACS_SINGLE_F1,
    parameter logic [21:0] FIRST_F0  [10] = `ACS_FIRST_F0,
    parameter logic [21:0] FIRST_F1  [10] = `ACS_FIRST_F1,
    parameter logic [21:0] NEXT_F0   [10] = `ACS_NEXT_F0,
    parameter logic [21:0] NEXT_F1   [10] = `ACS_NEXT_F1
) (
    input  logic        CLOCK,
    input  logic        SYS_RST,
    input  logic        SCLK,
    input  logic        SERIAL_DATA_IN,
    input  logic        CS_N,
    input  logic [3:0]  WORD_RATE_SELECT,
    input  logic        FILTER_RATE_SELECT,
    input  logic        BIPOLAR,
    input  logic [31:0] RAW_DATA,
    input  logic [31:0] CAL_VALUE,
    output logic        SERIAL_DATA_OUT,
    output logic [7:0]  CMD_BYTE,
    output logic        CMD_STROBE,
    output logic        CONV_ACTIVE,
    output logic        CONV_BIPOLAR,
    output logic [31:0] GAIN_VALUE,
    output logic [31:0] OFFSET_VALUE
);
    logic               sclk_s;
    logic               sdi_s;
    logic               csn_s;
    logic               sclk_d;
    logic               rise;
    logic               fall;
    acs_pkg::acs_port_e pstate;
    logic [5:0]         bit_cnt;
    logic [7:0]         cmd_sr;
    logic [7:0]         flag_sr;
    logic [7:0]         next_cmd;
    logic [7:0]         flag_byte;
    logic               cmd_done;
    logic               cmd_go;
    logic               is_single;
    logic               is_cont;
    logic               is_cal;
    logic               flag_done;
    logic               exit_now;
    logic               read_done;
    logic               cont_mode;
    logic               cal_run;
    logic               cal_gain;
    logic               frs_l;
    logic [3:0]         rate_l;
    logic [3:0]         rate_idx;
    logic               start_pend;
    logic               cal_low;
    logic [21:0]        conv_cnt;
    logic [21:0]        single_cyc;
    logic [21:0]        first_cyc;
    logic [21:0]        next_cyc;
    logic [21:0]        cal_cyc;
    logic               conv_run;
    logic               conv_zero;
    logic               conv_end;
    logic               cal_done;
    logic               eng_abort;
    logic [31:0]        data_reg;
    logic [31:0]        shift_reg;
    logic [4:0]         rise_cnt;
    logic               new_result;
    logic signed [49:0] ofs_prod;
    logic signed [34:0] ofs_sum;
    logic signed [65:0] gain_prod;

    acs_stream_if #(.W(32)) res_if ();

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation and serial clock edges.
    acs_sync #(.W(3), .INIT(3'h5)) u_sync (
        .clk (CLOCK),
        .rst (SYS_RST),
        .d   ({SCLK, SERIAL_DATA_IN, CS_N}),
        .q   ({sclk_s, sdi_s, csn_s})
    );

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sclk_d <= 1'b1;
        end else begin
            sclk_d <= sclk_s;
        end
    end

    // Edges are seen a few clocks late, which moves the start slightly.
    assign rise      = sclk_s && !sclk_d && !csn_s;
    assign fall      = !sclk_s && sclk_d && !csn_s;
    assign next_cmd  = {cmd_sr[6:0], sdi_s};
    assign flag_byte = {flag_sr[6:0], sdi_s};
    assign cmd_done  = (pstate == acs_pkg::PS_CMD) && rise && (bit_cnt == `ACS_BYTE_LAST);
    assign is_cal    = next_cmd[`ACS_CAL_BIT];
    assign is_single = !is_cal && (next_cmd == `ACS_CMD_SINGLE);
    assign is_cont   = !is_cal && (next_cmd == `ACS_CMD_CONT);
    assign cmd_go    = cmd_done && (is_single || is_cont || is_cal);
    assign flag_done = (pstate == acs_pkg::PS_FLAG) && rise && (bit_cnt == `ACS_BYTE_LAST);
    assign read_done = (pstate == acs_pkg::PS_SHIFT) && rise && (bit_cnt == `ACS_READ_LAST);
    // The flag byte is only decoded in continuous mode; single mode relies on zeros.
    assign exit_now  = flag_done && cont_mode && (flag_byte == `ACS_EXIT_BYTE);
    assign eng_abort = exit_now || ((pstate == acs_pkg::PS_CAL) && rise);

    ////////////////////////////////////////////////////////////////////////////////
    // Cycle counts from the latched rate settings.
    always_comb begin
        rate_idx = {1'b0, WORD_RATE_SELECT[2:0]};
        if (WORD_RATE_SELECT[2:0] > 3'h4) begin
            rate_idx = 4'h4;
        end
        if (WORD_RATE_SELECT[3]) begin
            rate_idx = rate_idx + 4'h5;
        end
    end

    always_comb begin
        single_cyc = frs_l ? SINGLE_F1[rate_l] : SINGLE_F0[rate_l];
        first_cyc  = frs_l ? FIRST_F1[rate_l] : FIRST_F0[rate_l];
        next_cyc   = frs_l ? NEXT_F1[rate_l] : NEXT_F0[rate_l];
        // Calibration paces at the selected word rate.
        if (cal_gain) begin
            cal_cyc = single_cyc - (frs_l ? `ACS_GAIN_LESS_F1 : `ACS_GAIN_LESS_F0);
        end else begin
            cal_cyc = single_cyc - (frs_l ? `ACS_OFS_LESS_F1 : `ACS_OFS_LESS_F0);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Command capture and settings snapshot.
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            cont_mode    <= 1'b0;
            cal_run      <= 1'b0;
            cal_gain     <= 1'b0;
            frs_l        <= 1'b0;
            rate_l       <= 4'h0;
            CONV_BIPOLAR <= 1'b0;
            start_pend   <= 1'b0;
        end else begin
            start_pend <= cmd_go;
            if (cmd_go) begin
                // Rate and polarity are frozen for the whole run.
                cont_mode    <= is_cont;
                cal_run      <= is_cal;
                cal_gain     <= next_cmd[`ACS_CAL_GAIN_BIT];
                frs_l        <= FILTER_RATE_SELECT;
                rate_l       <= rate_idx;
                CONV_BIPOLAR <= BIPOLAR;
            end else begin
                if (exit_now) begin
                    cont_mode <= 1'b0;
                end
                if (cal_done || eng_abort) begin
                    cal_run <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            CMD_STROBE <= 1'b0;
            CMD_BYTE   <= 8'h00;
        end else begin
            CMD_STROBE <= cmd_done && !cmd_go;
            if (cmd_done && !cmd_go) begin
                CMD_BYTE <= next_cmd;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Conversion engine.
    assign conv_zero = conv_run && (conv_cnt == 22'h0);
    assign conv_end  = conv_zero && !cal_run && res_if.in_ready;
    assign cal_done  = conv_zero && cal_run && !eng_abort;
    assign CONV_ACTIVE = conv_run;

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            conv_run <= 1'b0;
            conv_cnt <= 22'h0;
        end else if (eng_abort) begin
            conv_run <= 1'b0;
        end else if (start_pend) begin
            conv_run <= 1'b1;
            if (cal_run) begin
                conv_cnt <= cal_cyc - 22'h1;
            end else if (cont_mode) begin
                conv_cnt <= first_cyc - 22'h1;
            end else begin
                conv_cnt <= single_cyc - 22'h1;
            end
        end else if (conv_run && (conv_cnt != 22'h0)) begin
            conv_cnt <= conv_cnt - 22'h1;
        end else if (conv_end && cont_mode) begin
            conv_cnt <= next_cyc - 22'h1;
        end else if (conv_end || cal_done) begin
            // Only the final settled word leaves a single run.
            conv_run <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Offset and gain correction, result FIFO and data register.
    assign ofs_prod  = $signed(OFFSET_VALUE) * `ACS_OFS_SCALE;
    assign ofs_sum   = $signed({{3{RAW_DATA[31]}}, RAW_DATA}) + $signed(ofs_prod[49:16]);
    assign gain_prod = ofs_sum * $signed({1'b0, GAIN_VALUE[29:0]});

    assign res_if.in_valid  = conv_zero && !cal_run;
    assign res_if.in_data   = {gain_prod[55:32], RAW_DATA[7:0]};
    assign res_if.out_ready = (pstate != acs_pkg::PS_FLAG);
    assign new_result       = res_if.out_valid && res_if.out_ready;

    acs_fifo #(.W(32), .DEPTH(16)) u_fifo (
        .clk (CLOCK),
        .rst (SYS_RST),
        .s   (res_if.fifo)
    );

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            data_reg <= 32'h0;
        end else if (new_result) begin
            data_reg <= res_if.out_data;
        end
    end

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            GAIN_VALUE   <= `ACS_GAIN_RESET;
            OFFSET_VALUE <= `ACS_OFS_RESET;
        end else if (cal_done && cal_gain) begin
            GAIN_VALUE <= CAL_VALUE & `ACS_GAIN_MASK;
        end else if (cal_done) begin
            OFFSET_VALUE <= CAL_VALUE & `ACS_OFS_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Serial port mode machine.
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pstate    <= acs_pkg::PS_CMD;
            bit_cnt   <= 6'h00;
            cmd_sr    <= 8'h00;
            flag_sr   <= 8'h00;
            shift_reg <= 32'h0;
        end else begin
            unique case (pstate)
                acs_pkg::PS_CMD: begin
                    if (csn_s) begin
                        bit_cnt <= 6'h00;
                    end else if (rise) begin
                        cmd_sr  <= next_cmd;
                        bit_cnt <= bit_cnt + 6'h01;
                        if (cmd_done) begin
                            bit_cnt <= 6'h00;
                            if (is_cal) begin
                                pstate <= acs_pkg::PS_CAL;
                            end else if (is_single || is_cont) begin
                                pstate <= acs_pkg::PS_WAIT;
                            end
                        end
                    end
                end
                acs_pkg::PS_CAL: begin
                    if (eng_abort || cal_done) begin
                        pstate <= acs_pkg::PS_CMD;
                    end
                end
                acs_pkg::PS_WAIT: begin
                    if (new_result) begin
                        pstate <= acs_pkg::PS_READY;
                    end
                end
                acs_pkg::PS_READY: begin
                    if (rise) begin
                        flag_sr <= {7'h00, sdi_s};
                        bit_cnt <= 6'h01;
                        pstate  <= acs_pkg::PS_FLAG;
                    end
                end
                acs_pkg::PS_FLAG: begin
                    if (rise) begin
                        flag_sr <= flag_byte;
                        bit_cnt <= bit_cnt + 6'h01;
                    end
                    if (flag_done) begin
                        shift_reg <= data_reg;
                        pstate    <= acs_pkg::PS_SHIFT;
                    end
                end
                acs_pkg::PS_SHIFT: begin
                    if (rise) begin
                        bit_cnt <= bit_cnt + 6'h01;
                    end
                    if (fall) begin
                        shift_reg <= {shift_reg[30:0], 1'b0};
                    end
                    if (read_done) begin
                        bit_cnt <= 6'h00;
                        pstate  <= cont_mode ? acs_pkg::PS_WAIT : acs_pkg::PS_CMD;
                    end
                end
                default: begin
                    pstate <= acs_pkg::PS_CMD;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Data-out line.
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            cal_low <= 1'b0;
        end else if (cal_done) begin
            cal_low <= 1'b1;
        end else if ((pstate == acs_pkg::PS_CMD) && rise) begin
            cal_low <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            rise_cnt <= 5'h00;
        end else if (new_result && (pstate == acs_pkg::PS_READY) && cont_mode) begin
            rise_cnt <= `ACS_RISE_CYC;
        end else if (rise_cnt != 5'h00) begin
            rise_cnt <= rise_cnt - 5'h01;
        end
    end

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            SERIAL_DATA_OUT <= 1'b1;
        end else if (pstate == acs_pkg::PS_SHIFT) begin
            if (fall) begin
                SERIAL_DATA_OUT <= shift_reg[31];
            end
        end else if ((pstate == acs_pkg::PS_READY) && (rise_cnt != 5'h00)) begin
            SERIAL_DATA_OUT <= 1'b1;
        end else begin
            SERIAL_DATA_OUT <= !((pstate == acs_pkg::PS_READY) || (pstate == acs_pkg::PS_FLAG) ||
                     ((pstate == acs_pkg::PS_CMD) && cal_low));
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions.
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);

    a_ready_sdo_low: assert property (
        (pstate == acs_pkg::PS_READY) && (rise_cnt == 5'h00) |=> !SERIAL_DATA_OUT)
        else $error("data ready not flagged low");
    a_single_length: assert property (
        $rose(conv_run) && !cont_mode && !cal_run |-> conv_cnt == single_cyc - 22'h1)
        else $error("single conversion length wrong");
    a_cont_first_len: assert property (
        $rose(conv_run) && cont_mode |-> conv_cnt == first_cyc - 22'h1)
        else $error("first continuous length wrong");
    a_cont_next_len: assert property (
        conv_end && cont_mode && !eng_abort && !start_pend |=>
        conv_run && (conv_cnt == $past(next_cyc) - 22'h1))
        else $error("later continuous length wrong");
    a_single_one_word: assert property (
        conv_end && !cont_mode && !eng_abort && !start_pend |=> !conv_run && !res_if.in_valid)
        else $error("single run produced more than one word");
    a_cmd_data_mode: assert property (
        cmd_done && (is_single || is_cont) |=> (pstate == acs_pkg::PS_WAIT) [*2])
        else $error("port did not enter data mode");
    a_flag_then_data: assert property (
        flag_done |=> (pstate == acs_pkg::PS_SHIFT) && (bit_cnt == 6'h08) && !SERIAL_DATA_OUT)
        else $error("flag clocks did not lead to data clocks");
    a_single_return: assert property (
        read_done && !cont_mode |=> pstate == acs_pkg::PS_CMD)
        else $error("single read did not return to command mode");
    a_exit_cont: assert property (
        exit_now |=> !cont_mode && !conv_run && (pstate == acs_pkg::PS_SHIFT))
        else $error("exit byte did not end continuous mode");
    a_cal_end_low: assert property (
        cal_done |-> ##2 !SERIAL_DATA_OUT && (pstate == acs_pkg::PS_CMD))
        else $error("calibration end not flagged low");
    a_cal_abort: assert property (
        (pstate == acs_pkg::PS_CAL) && rise |=> !conv_run && !cal_run)
        else $error("port access did not halt calibration");
endmodule

// *** sim/acs_host.sv ***
// Host model: drives the serial port and collects result frames.
module acs_host (
    input  wire logic clk,
    input  wire logic miso,
    output logic      sck,
    output logic      mosi,
    output logic      cs_n
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        sck = 1'b1;
        mosi = 1'b1;
        cs_n = 1'b0;
    end
    // One serial clock of 16 system clocks; the result line is sampled at the rise.
    task automatic bit_xfer(input logic b, output logic q);
        sck = 1'b0;
        mosi = b;
        repeat (8) @(posedge clk);
        #1 sck = 1'b1;
        q = miso;
        repeat (8) @(posedge clk);
        #1;
    endtask
    task automatic cmd(input logic [7:0] c);
        logic q;
        for (int i = 7; i >= 0; i--) bit_xfer(c[i], q);
        mosi = ~c[0];
    endtask
    task automatic read(input logic [7:0] f, output logic [31:0] d);
        logic q;
        for (int i = 7; i >= 0; i--) bit_xfer(f[i], q);
        for (int i = 31; i >= 0; i--) bit_xfer(1'b0, d[i]);
        mosi = 1'b1;
    endtask
endmodule

// *** sim/acs_sequencer_tb.sv ***
// Self-checking bench of the conversion sequencer.
module acs_sequencer_tb;
    timeunit 1ns;
    timeprecision 100ps;
    typedef logic [21:0] acs_tab_t [10];
    typedef struct packed {logic [3:0] c; logic f; logic [31:0] r;} acs_row_s;
    logic clk = 0, rst = 1, fsel = 0, bip = 0, sck, mosi, cs_n, miso, active, cbip, qb, strb;
    logic [3:0] rate = 4'h0;
    logic [31:0] raw = 32'h0, cal = 32'h0, gain, ofs, d;
    logic [7:0] cbyte;
    int err_count = 0;
    int check_count = 0;
    int strobes = 0;
    int n;
    acs_row_s rows [5] = '{{4'h0, 1'b0, 32'h12345678}, {4'h4, 1'b1, 32'hFEDCBA98},
        {4'h8, 1'b0, 32'h00000001}, {4'hC, 1'b1, 32'h80000000}, {4'hF, 1'b0, 32'h7FFFFF00}};
    function automatic acs_tab_t mk(int b);
        for (int i = 0; i < 10; i++) mk[i] = 22'(b + 10 * i);
    endfunction
    function automatic int idx(logic [3:0] c);
        return (c[3] ? 5 : 0) + (c[2] ? 4 : int'(c[1:0]));
    endfunction
    always #5 clk = ~clk;
    always @(posedge clk) if (strb === 1'b1) strobes++;
    acs_host host (.clk(clk), .miso(miso), .sck(sck), .mosi(mosi), .cs_n(cs_n));
    acs_sequencer #(.SINGLE_F0(mk(900)), .SINGLE_F1(mk(1100)), .FIRST_F0(mk(700)),
        .FIRST_F1(mk(800)), .NEXT_F0(mk(1200)), .NEXT_F1(mk(1300))) uut (
        .CLOCK(clk), .SYS_RST(rst), .SCLK(sck), .SERIAL_DATA_IN(mosi), .CS_N(cs_n),
        .WORD_RATE_SELECT(rate), .FILTER_RATE_SELECT(fsel), .BIPOLAR(bip), .RAW_DATA(raw),
        .CAL_VALUE(cal), .SERIAL_DATA_OUT(miso), .CMD_BYTE(cbyte), .CMD_STROBE(strb), .CONV_ACTIVE(active),
        .CONV_BIPOLAR(cbip), .GAIN_VALUE(gain), .OFFSET_VALUE(ofs));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk_near(input int g, input int e, input int tol);
        check_count++;
        if (g < e - tol || g > e + tol) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Counts clocks until the result line shows the level, bounded.
    task automatic wait_lvl(input logic v, output int k);
        k = 0;
        while (miso !== v && k < 20000) begin
            @(posedge clk);
            #1 k++;
        end
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #400us err_count++;
        conclude();
    end
    initial begin
        repeat (12) @(posedge clk);
        #1 rst = 0;
        repeat (4) @(posedge clk);
        #1;
        foreach (rows[i]) begin
            rate = rows[i].c;
            fsel = rows[i].f;
            bip = ~rows[i].f;
            raw = rows[i].r;
            host.cmd(8'h01);
            chk(32'(active), 32'h1);
            wait_lvl(1'b0, n);
            chk_near(n, (rows[i].f ? 1100 : 900) + 10 * idx(rows[i].c), 2);
            chk(32'(cbip), 32'(bip));
            host.read(8'h00, d);
            chk(d, rows[i].r);
            chk(32'(miso), 32'h1);
        end
        rate = 4'h0;
        fsel = 0;
        raw = 32'h0000AA11;
        host.cmd(8'h02);
        wait_lvl(1'b0, n);
        chk_near(n, 700, 2);
        raw = 32'h0000BB22;
        host.read(8'h00, d);
        chk(d, 32'h0000AA11);
        wait_lvl(1'b0, n);
        raw = 32'h0000CC33;
        wait_lvl(1'b1, n);
        chk_near(n, 1200, 2);
        wait_lvl(1'b0, n);
        host.read(8'hFF, d);
        chk(d, 32'h0000CC33);
        host.cmd(8'h55);
        chk(32'(cbyte), 32'h55);
        cal = 32'hA5A5A5FF;
        host.cmd(8'h80);
        wait_lvl(1'b0, n);
        chk_near(n, 900 - 608, 10);
        chk(ofs, 32'hA5A5A500);
        cal = 32'hC2000000;
        host.cmd(8'h81);
        wait_lvl(1'b0, n);
        chk_near(n, 900 - 128, 10);
        chk(gain, 32'h02000000);
        host.cmd(8'h80);
        host.bit_xfer(1'b0, qb);
        repeat (400) @(posedge clk);
        #1;
        chk({active, miso}, 32'h1);
        chk(ofs, 32'hA5A5A500);
        chk(32'(strobes), 32'h1);
        rst = 1;
        repeat (2) @(posedge clk);
        #1;
        chk(gain, 32'h01000000);
        chk(ofs, 32'h00000000);
        chk({active, miso}, 32'h1);
        conclude();
    end
endmodule
